/* File: src/flash_seq_pkg.sv */
// Shared constants and carriers for the margin and blank-check sequencer
package flash_seq_pkg;
  // Command codes, carried in the high byte of parameter word 0
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_EE_VERIFY = 8'h10;
  // Field positions inside parameter word 0
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 8;
  localparam int ADDR_HI_MSB = 7;
  localparam int ADDR_HI_LSB = 0;
  // Parameter index value required at launch
  localparam logic [2:0] PARAM_IDX_REQ = 3'h2;
  // Margin level settings
  localparam logic [15:0] LVL_NORMAL = 16'h0000;
  localparam logic [15:0] LVL_USER_ERASED = 16'h0001;
  localparam logic [15:0] LVL_USER_PROG = 16'h0002;
  localparam logic [15:0] LVL_FIELD_ERASED = 16'h0003;
  localparam logic [15:0] LVL_FIELD_PROG = 16'h0004;
  localparam logic [15:0] USER_LVL_MAX = LVL_USER_PROG;
  localparam logic [15:0] FIELD_LVL_MAX = LVL_FIELD_PROG;
  localparam int LVL_W = 3;
  localparam logic [2:0] MARGIN_RST = 3'h0;
  // Erased state of one EEPROM word
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Address step between EEPROM words
  localparam logic [23:0] WORD_STEP = 24'h000002;
  // Reset values of the status flags
  localparam logic CMD_COMPLETE_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;

  // The three command parameter words loaded by software
  typedef struct packed {
    logic [15:0] word2;
    logic [15:0] word1;
    logic [15:0] word0;
  } cmd_words_t;

  // One answer from the EEPROM array read port
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic corr_err;
    logic uncorr_err;
  } rd_rsp_t;

  // Read margin levels in force for each array
  typedef struct packed {
    logic [2:0] pflash;
    logic [2:0] eeprom;
  } margin_t;
endpackage

/* File: src/sticky_flag.sv */
`timescale 1ns/1ps
`default_nettype none
// One status flag: hardware sets, another party clears, set wins
module sticky_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Set and clear requests
  input wire logic set,
  input wire logic clr,
  // Flag value
  output logic flag
);

  // A set in the same cycle as a clear keeps the event
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag <= RST_VAL;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: src/flash_margin_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - User margin: code 0x0D, address, setting
// - User margin stores level, then completes
// - Program block margin also covers EEPROM
// - User margin accepts settings zero to two
// - Parameter index must equal two
// - Out-of-set margin setting flags access error
// - Bad mode or address flags access error
// - Field margin: code 0x0E, special only
// - Field margin stores level, then completes
// - Program block field margin covers EEPROM
// - Field margin accepts settings zero to four
// - Verify: code 0x10, address, count
// - Verify blank section, failure sets both
// - Verify address must be word aligned
// - Verify section must fit the EEPROM
// - Read errors set status bits accordingly
module flash_margin_seq #(
  parameter logic [23:0] PF_FIRST = 24'h800000,
  parameter logic [23:0] PF_LAST = 24'hFFFFFF,
  parameter logic [23:0] EE_FIRST = 24'h100000,
  parameter logic [23:0] EE_LAST = 24'h1003FF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command launch from software
  input wire logic cmd_launch,
  input wire logic [2:0] param_index,
  input wire flash_seq_pkg::cmd_words_t cmd_param_array,
  input wire logic special_mode,
  input wire logic access_error_clr,
  // Status flags
  output logic cmd_complete_flag,
  output logic access_error_flag,
  output logic protection_violation_flag,
  output logic verify_error_bit,
  output logic uncorrectable_error_bit,
  // Margin levels applied to array reads
  output flash_seq_pkg::margin_t read_margin,
  // EEPROM array read port
  output logic rd_req,
  output logic [23:0] rd_addr,
  input wire flash_seq_pkg::rd_rsp_t rd_rsp
);
  import flash_seq_pkg::*;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_READ = 2'b10,
    ST_DONE = 2'b11
  } seq_state_t;

  seq_state_t state; // Current sequencer state
  logic [2:0] cap_idx; // Index captured at launch
  cmd_words_t cap_words; // Parameters captured at launch
  logic [15:0] remaining; // Words still to verify
  logic launch_ok; // Launch accepted this cycle
  logic [7:0] code; // Command code field
  logic [23:0] addr; // Global target address
  logic [15:0] lvl; // Requested margin setting
  logic [LVL_W-1:0] lvl_code; // Setting at storage width
  logic is_user; // User margin command
  logic is_field; // Field margin command
  logic is_verify; // EEPROM blank check
  logic is_margin; // Either margin command
  logic in_pf; // Address inside program array
  logic in_ee; // Address inside EEPROM
  logic idx_err; // Wrong parameter index
  logic unk_err; // Unknown command code
  logic mode_err; // Command barred in this mode
  logic addr_err; // Address hits no valid block
  logic lvl_err; // Setting outside valid set
  logic align_err; // Odd verify address
  logic range_err; // Section runs past EEPROM end
  logic any_err; // Any launch check failed
  logic [25:0] sect_end; // One past the last checked byte
  logic [25:0] ee_limit; // One past the EEPROM end
  logic acc_set; // Raise access error
  logic blank_fail; // Read word is not erased
  logic ver_set; // Raise verify error bit
  logic unc_set; // Raise uncorrectable error bit
  logic last_word; // Final word of the section

  // Launch only counts while the previous command is complete
  assign launch_ok = cmd_launch && cmd_complete_flag;

  // Field decode of the captured words
  assign code = cap_words.word0[CODE_MSB:CODE_LSB];
  assign addr = {cap_words.word0[ADDR_HI_MSB:ADDR_HI_LSB], cap_words.word1};
  assign lvl = cap_words.word2;
  assign lvl_code = lvl[LVL_W-1:0];
  assign is_user = (code == CMD_USER_MARGIN);
  assign is_field = (code == CMD_FIELD_MARGIN);
  assign is_verify = (code == CMD_EE_VERIFY);
  assign is_margin = is_user || is_field;

  // Block decode of the global address
  assign in_pf = (addr >= PF_FIRST) && (addr <= PF_LAST);
  assign in_ee = (addr >= EE_FIRST) && (addr <= EE_LAST);

  // Section end is computed wide so a large count cannot wrap
  assign sect_end = {2'b00, addr} + {9'b0_0000_0000, lvl, 1'b0};
  assign ee_limit = {2'b00, EE_LAST} + 26'h0000001;

  // Launch checks, all evaluated in one cycle
  always_comb begin
    idx_err = (cap_idx != PARAM_IDX_REQ);
    unk_err = !(is_margin || is_verify);
    mode_err = is_field && !special_mode;
    // Verify must land in EEPROM, margins in either block
    if (is_verify) begin
      addr_err = !in_ee;
    end else begin
      addr_err = !(in_pf || in_ee);
    end
    // Valid setting set depends on the command
    if (is_user) begin
      lvl_err = (lvl > USER_LVL_MAX);
    end else if (is_field) begin
      lvl_err = (lvl > FIELD_LVL_MAX);
    end else begin
      lvl_err = 1'b0;
    end
    align_err = is_verify && addr[0];
    range_err = is_verify && (sect_end > ee_limit);
    any_err = idx_err || unk_err || mode_err || addr_err || lvl_err || align_err
              || range_err;
  end

  // Capture of index and words at launch
  // Software may rewrite the array while busy; the copy keeps us steady
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_idx <= 3'h0;
      cap_words <= '0;
    end else if (launch_ok) begin
      cap_idx <= param_index;
      cap_words <= cmd_param_array;
    end
  end

  // Sequencer state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch_ok) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // An errored launch skips straight to completion
          if (any_err) begin
            state <= ST_DONE;
          end else if (is_verify && (lvl != 16'h0000)) begin
            state <= ST_READ;
          end else begin
            state <= ST_DONE;
          end
        end
        ST_READ: begin
          if (rd_rsp.valid && last_word) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Completion flag: cleared by an accepted launch, set when done
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_complete_flag <= CMD_COMPLETE_RST;
    end else if (state == ST_DONE) begin
      cmd_complete_flag <= 1'b1;
    end else if (launch_ok) begin
      cmd_complete_flag <= 1'b0;
    end
  end

  // Margin storage; a program block setting reaches EEPROM too
  // There is no way to margin the program array alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_margin <= {MARGIN_RST, MARGIN_RST};
    end else if ((state == ST_CHECK) && !any_err && is_margin) begin
      if (in_pf) begin
        read_margin.pflash <= lvl_code;
        read_margin.eeprom <= lvl_code;
      end else begin
        read_margin.eeprom <= lvl_code;
      end
    end
  end

  // Blank check walk over the section
  assign last_word = (remaining == 16'h0001);
  assign rd_req = (state == ST_READ);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_addr <= 24'h000000;
      remaining <= 16'h0000;
    end else if (state == ST_CHECK) begin
      rd_addr <= addr;
      remaining <= lvl;
    end else if (rd_req && rd_rsp.valid) begin
      rd_addr <= rd_addr + WORD_STEP;
      remaining <= remaining - 16'h0001;
    end
  end

  // Error events of the walk
  assign blank_fail = rd_req && rd_rsp.valid && (rd_rsp.data != ERASED_WORD);
  assign ver_set = blank_fail || (rd_req && rd_rsp.valid
                   && (rd_rsp.corr_err || rd_rsp.uncorr_err));
  assign unc_set = blank_fail || (rd_req && rd_rsp.valid && rd_rsp.uncorr_err);
  assign acc_set = (state == ST_CHECK) && any_err;

  // Access error stays until software clears it
  sticky_flag #(.RST_VAL(FLAG_RST)) u_acc_flag (
    .ref_clk(ref_clk),
    .rst(rst),
    .set(acc_set),
    .clr(access_error_clr),
    .flag(access_error_flag)
  );

  // Verify status bits start fresh at every launch
  sticky_flag #(.RST_VAL(FLAG_RST)) u_ver_flag (
    .ref_clk(ref_clk),
    .rst(rst),
    .set(ver_set),
    .clr(launch_ok),
    .flag(verify_error_bit)
  );

  sticky_flag #(.RST_VAL(FLAG_RST)) u_unc_flag (
    .ref_clk(ref_clk),
    .rst(rst),
    .set(unc_set),
    .clr(launch_ok),
    .flag(uncorrectable_error_bit)
  );

  // These commands touch no protected area
  assign protection_violation_flag = 1'b0;

  // Checks on the sequencer
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Accepted launch drops completion at once
  AST_LAUNCH_CLEARS: assert property (launch_ok |=> !cmd_complete_flag)
    else $error("completion flag did not drop on launch");

  // Good margin command completes two cycles after its check
  AST_MARGIN_DONE: assert property ((state == ST_CHECK) && !any_err && is_margin
    |-> ##2 cmd_complete_flag)
    else $error("margin command did not complete");

  // Wrong index raises access error
  AST_IDX_ERR: assert property ((state == ST_CHECK) && idx_err
    |=> access_error_flag)
    else $error("bad index not flagged");

  // Bad setting raises access error
  AST_LVL_ERR: assert property ((state == ST_CHECK) && lvl_err
    |=> access_error_flag)
    else $error("bad margin setting not flagged");

  // Field margin outside special mode refused
  AST_MODE_ERR: assert property ((state == ST_CHECK) && is_field && !special_mode
    |=> access_error_flag && $stable(read_margin))
    else $error("field margin ran outside special mode");

  // Odd verify address refused
  AST_ALIGN_ERR: assert property ((state == ST_CHECK) && is_verify && addr[0]
    |=> access_error_flag && !rd_req)
    else $error("misaligned verify not refused");

  // Section past the end refused
  AST_RANGE_ERR: assert property ((state == ST_CHECK) && range_err
    |=> access_error_flag && !rd_req)
    else $error("section breach not refused");

  // Errored launch keeps margins and still completes
  AST_ERR_SKIPS: assert property ((state == ST_CHECK) && any_err
    |=> $stable(read_margin) ##1 cmd_complete_flag)
    else $error("errored launch changed margins or hung");

  // Program block setting lands on both arrays
  AST_PF_BOTH: assert property ((state == ST_CHECK) && !any_err && is_margin && in_pf
    |=> (read_margin.pflash == $past(lvl_code))
        && (read_margin.eeprom == $past(lvl_code)))
    else $error("program block margin not applied to both");

  // EEPROM setting leaves the program array alone
  AST_EE_ONLY: assert property ((state == ST_CHECK) && !any_err && is_margin && !in_pf
    |=> $stable(read_margin.pflash)
        && (read_margin.eeprom == $past(lvl_code)))
    else $error("EEPROM margin leaked to program array");

  // Non-blank word sets both status bits
  AST_BLANK_FAIL: assert property (blank_fail
    |=> verify_error_bit && uncorrectable_error_bit)
    else $error("blank check failure not reported");

  // Correctable error alone sets only the first bit
  AST_CORR_ONLY: assert property (rd_req && rd_rsp.valid && rd_rsp.corr_err
    && !rd_rsp.uncorr_err && (rd_rsp.data == ERASED_WORD) && !uncorrectable_error_bit
    |=> verify_error_bit && !uncorrectable_error_bit)
    else $error("correctable error misreported");

  // Main scenarios
  COV_USER_MARGIN: cover property ((state == ST_CHECK) && is_user && !any_err);
  COV_FIELD_MARGIN: cover property ((state == ST_CHECK) && is_field && !any_err);
  COV_VERIFY_PASS: cover property (rd_req && rd_rsp.valid && last_word && !blank_fail);
  COV_ACC_ERR: cover property (acc_set);

endmodule
`default_nettype wire

/* File: testbench/flash_margin_and_blank_check_cmds_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Compare, count, and report a mismatch at once
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module flash_margin_and_blank_check_cmds_tb;
  import flash_seq_pkg::*;
  // Address map handed to the design, so every expectation follows it
  localparam logic [23:0] PF_F = 24'h800000;
  localparam logic [23:0] PF_L = 24'hFFFFFF;
  localparam logic [23:0] EE_F = 24'h100000;
  localparam logic [23:0] EE_L = 24'h1003FF;
  // Design stimulus
  logic ref_clk, rst, cmd_launch, special_mode, access_error_clr;
  logic [2:0] param_index;
  cmd_words_t cmd_param_array;
  rd_rsp_t rd_rsp;
  // Design outputs
  logic cmd_complete_flag, access_error_flag, protection_violation_flag;
  logic verify_error_bit, uncorrectable_error_bit, rd_req;
  logic [23:0] rd_addr;
  margin_t read_margin;
  // Bench state: inj picks the fault on one word (1 data, 2 corrected, 3 uncorrectable)
  int fails, tests_run, nreads, inj;
  logic [23:0] exp_addr, bad_addr;
  margin_t exp_margin;

  flash_margin_seq #(.PF_FIRST(PF_F), .PF_LAST(PF_L), .EE_FIRST(EE_F), .EE_LAST(EE_L)) uut (
    .ref_clk(ref_clk), .rst(rst), .cmd_launch(cmd_launch), .param_index(param_index),
    .cmd_param_array(cmd_param_array), .special_mode(special_mode),
    .access_error_clr(access_error_clr), .cmd_complete_flag(cmd_complete_flag),
    .access_error_flag(access_error_flag), .protection_violation_flag(protection_violation_flag),
    .verify_error_bit(verify_error_bit), .uncorrectable_error_bit(uncorrectable_error_bit),
    .read_margin(read_margin), .rd_req(rd_req), .rd_addr(rd_addr), .rd_rsp(rd_rsp));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Array answers after a random delay; data lines carry noise while not valid,
  // so a design that samples early cannot pass by luck
  always @(negedge ref_clk) begin : rsp_drv
    logic v, hit;
    v = rd_req && ($urandom_range(1, 0) == 1);
    hit = v && (rd_addr == bad_addr);
    rd_rsp.valid <= v;
    rd_rsp.data <= (hit && inj == 1) ? 16'h00FF : (v ? ERASED_WORD : 16'($urandom));
    rd_rsp.corr_err <= hit && inj == 2;
    rd_rsp.uncorr_err <= hit && inj == 3;
  end

  // Every consumed word must come in rising word order
  always @(posedge ref_clk) begin
    if (rd_req && rd_rsp.valid) begin
      `CHK("rd_addr", exp_addr, rd_addr)
      exp_addr = exp_addr + WORD_STEP;
      nreads++;
    end
  end

  function automatic logic in_pf(logic [23:0] a);
    in_pf = a >= PF_F && a <= PF_L;
  endfunction
  function automatic logic in_ee(logic [23:0] a);
    in_ee = a >= EE_F && a <= EE_L;
  endfunction

  // Predicted access error for one launch
  function automatic logic exp_err(logic [2:0] idx, cmd_words_t w, logic sp);
    logic [23:0] a;
    logic [24:0] e;
    a = {w.word0[7:0], w.word1};
    e = {1'b0, a} + {8'h00, w.word2, 1'b0};
    case (w.word0[15:8])
      CMD_USER_MARGIN: exp_err = !(in_pf(a) || in_ee(a)) || w.word2 > 16'h0002;
      CMD_FIELD_MARGIN: exp_err = !sp || !(in_pf(a) || in_ee(a)) || w.word2 > 16'h0004;
      CMD_EE_VERIFY: exp_err = !in_ee(a) || a[0] || e > {1'b0, EE_L} + 25'h1;
      default: exp_err = 1'b1;
    endcase
    if (idx != 3'b010) begin
      exp_err = 1'b1;
    end
  endfunction

  // Mostly the required index, sometimes any other
  function automatic logic [2:0] pick_idx();
    pick_idx = ($urandom_range(5, 0) == 0) ? 3'($urandom) : 3'h2;
  endfunction
  // EEPROM words (a few odd or past the end), program block, or unmapped
  function automatic logic [23:0] pick_addr();
    case ($urandom_range(3, 0))
      0: pick_addr = {1'b1, 23'($urandom)};
      1: pick_addr = 24'($urandom_range(24'h0FFFFF, 0));
      default: pick_addr = EE_F + 24'($urandom_range(520, 0) * 2) + 24'($urandom_range(7, 0) == 0);
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One command from launch to completion, then check flags, margins, reads; entered at negedge
  task automatic run(logic [2:0] idx, logic [7:0] code, logic [23:0] a, logic [15:0] s, int k);
    cmd_words_t w;
    logic err;
    int i;
    w = '{word2: s, word1: a[15:0], word0: {code, a[23:16]}};
    err = exp_err(idx, w, special_mode);
    inj = (!err && code == CMD_EE_VERIFY && s != 0) ? k : 0;
    if (s != 0 && s < 16'h0400) begin
      bad_addr = a + 24'($urandom_range(int'(s) - 1, 0) * 2);
    end
    exp_addr = a;
    nreads = 0;
    cmd_launch = 1'b1;
    param_index = idx;
    cmd_param_array = w;
    @(negedge ref_clk);
    // Launch held one more cycle with new words: a busy launch must be ignored
    param_index = 3'($urandom);
    cmd_param_array = {$urandom, 16'($urandom)};
    `CHK("cmd_complete_flag busy", 1'b0, cmd_complete_flag)
    @(negedge ref_clk);
    cmd_launch = 1'b0;
    `CHK("cmd_complete_flag still busy", 1'b0, cmd_complete_flag)
    for (i = 0; i < 2000 && cmd_complete_flag !== 1'b1; i++) @(negedge ref_clk);
    if (cmd_complete_flag !== 1'b1) begin
      fails++;
      end_of_test();
    end
    if (!err && code != CMD_EE_VERIFY) begin
      exp_margin.eeprom = s[2:0];
      if (in_pf(a)) begin
        exp_margin.pflash = s[2:0];
      end
    end
    `CHK("access_error_flag", err, access_error_flag)
    `CHK("read_margin", exp_margin, read_margin)
    `CHK("verify_error_bit", inj != 0, verify_error_bit)
    `CHK("uncorrectable_error_bit", inj == 1 || inj == 3, uncorrectable_error_bit)
    `CHK("read count", (err || code != CMD_EE_VERIFY) ? 0 : int'(s), nreads)
    `CHK("protection_violation_flag", 1'b0, protection_violation_flag)
    access_error_clr = 1'b1;
    @(negedge ref_clk);
    access_error_clr = 1'b0;
    `CHK("access_error_flag cleared", 1'b0, access_error_flag)
  endtask

  // Main sequence: reset, corner cases, then random commands
  initial begin
    void'($urandom(97489));
    {rst, cmd_launch, special_mode, access_error_clr} = 4'b1000;
    param_index = 3'h0;
    cmd_param_array = '0;
    exp_margin = '0;
    bad_addr = '0;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("cmd_complete_flag reset", 1'b1, cmd_complete_flag)
    `CHK("read_margin reset", exp_margin, read_margin)
    // Every setting, legal and not, on each block with both margin commands
    special_mode = 1'b1;
    for (int l = 0; l < 6; l++) begin
      run(3'h2, CMD_USER_MARGIN, EE_F, 16'(l), 0);
      run(3'h2, CMD_FIELD_MARGIN, PF_F, 16'(l), 0);
      run(3'h2, CMD_FIELD_MARGIN, EE_L, 16'(l), 0);
      run(3'h2, CMD_USER_MARGIN, PF_L, 16'(l), 0);
    end
    // Reset again with margins in force: every level returns to normal
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    exp_margin = '0;
    `CHK("read_margin after reset", exp_margin, read_margin)
    `CHK("cmd_complete_flag after reset", 1'b1, cmd_complete_flag)
    // Refusals: normal mode, wrong index, unmapped address, unknown code
    special_mode = 1'b0;
    run(3'h2, CMD_FIELD_MARGIN, PF_F, 16'h0003, 0);
    run(3'h1, CMD_USER_MARGIN, EE_F, 16'h0001, 0);
    run(3'h3, CMD_EE_VERIFY, EE_F, 16'h0001, 0);
    run(3'h2, CMD_USER_MARGIN, 24'h000000, 16'h0001, 0);
    run(3'h2, 8'h0F, EE_F, 16'h0000, 0);
    // Blank check: each fault kind, empty, exact fit, overrun, odd, wrong block, whole block
    for (int k = 0; k < 4; k++) run(3'h2, CMD_EE_VERIFY, EE_F + 24'h2, 16'h0004, k);
    run(3'h2, CMD_EE_VERIFY, EE_F, 16'h0000, 1);
    run(3'h2, CMD_EE_VERIFY, EE_L - 24'h1, 16'h0001, 3);
    run(3'h2, CMD_EE_VERIFY, EE_L - 24'h1, 16'h0002, 0);
    run(3'h2, CMD_EE_VERIFY, EE_F + 24'h1, 16'h0001, 0);
    run(3'h2, CMD_EE_VERIFY, PF_F, 16'h0001, 0);
    run(3'h2, CMD_EE_VERIFY, EE_F, 16'h0200, 2);
    // Random mix of commands, modes and faults
    for (int n = 0; n < 80; n++) begin
      special_mode = 1'($urandom);
      case ($urandom_range(3, 0))
        0: run(pick_idx(), CMD_USER_MARGIN, pick_addr(), 16'($urandom_range(4, 0)), 0);
        1: run(pick_idx(), CMD_FIELD_MARGIN, pick_addr(), 16'($urandom_range(6, 0)), 0);
        2: run(pick_idx(), CMD_EE_VERIFY, pick_addr(), 16'($urandom_range(8, 0)),
               $urandom_range(3, 0));
        default: run(3'($urandom), 8'($urandom), pick_addr(), 16'($urandom_range(9, 0)), 0);
      endcase
    end
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
